// ==== logic/ppm_pkg.sv ====
// Shared constants, states and carrier types of the parallel port mux
package ppm_pkg;
  // ==========================================================
  // Sizes
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // ==========================================================
  // Multiplexing select codes
  localparam logic [1:0] MUX_DEMUX = 2'h0;
  localparam logic [1:0] MUX_ONE   = 2'h1;
  localparam logic [1:0] MUX_TWO   = 2'h2;
  localparam logic [1:0] MUX_THREE = 2'h3;
  // Port width codes
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_4  = 2'h1;
  localparam logic [1:0] WID_16 = 2'h2;
  // Port mode codes
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_BUF    = 2'h1;
  localparam logic [1:0] MODE_ENH    = 2'h2;
  localparam logic [1:0] MODE_MASTER = 2'h3;
  // Address bits reachable: 1K, 16K, 64K, 2 Mbytes
  localparam logic [4:0] SPAN_1K  = 5'h0A;
  localparam logic [4:0] SPAN_16K = 5'h0E;
  localparam logic [4:0] SPAN_64K = 5'h10;
  localparam logic [4:0] SPAN_2M  = 5'h15;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOW   = 3'h1,
    ST_HIGH  = 3'h2,
    ST_UPPER = 3'h3,
    ST_DATA  = 3'h4
  } ppm_state_t;

  typedef struct packed {
    logic [1:0] port_width_sel;
    logic [1:0] addr_mux_sel;
    logic [1:0] port_mode;
    logic       latch_polarity_bit;
    logic       cs1_on_addr14;
    logic [1:0] strobe_mode_bit;   // [0] chip select 1, [1] chip select 2
  } ppm_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] ext_addr_lines;
    logic [ADDR_W-1:0] ext_addr_oe;
    logic [DATA_W-1:0] ext_data_lines;  // [15:8] is the upper data bus
    logic [DATA_W-1:0] ext_data_oe;
    logic              chip_sel_one;
    logic              chip_sel_two;
    logic              write_strobe_pin;  // also the enable strobe
    logic              write_strobe_oe;
    logic              read_strobe_pin;   // also read/write direction
    logic              read_strobe_oe;
    logic              high_byte_indicator;
    logic              low_lane_indicator;
  } ppm_pins_t;
endpackage

// ==== logic/ppm_addr_data_mux.sv ====
// Address/data pin multiplexer of the parallel bus port, master and slave
// Operation
// - Outgoing buffers a and b feed the port only in slave operation.
// - In slave operation host writes land in incoming buffers a or b.
// - Master reads return their data into incoming buffer a.
// - 8-bit demux drives address 9:0 on address lines, data on eight.
// - 4-bit port: data on lines 3:0, address in nibbles per phase.
// - Address is clipped to 1K, 16K, 64K or 2 Mbytes by width and mux.
// - 4-bit one-phase puts address 7:0 on data lines 7:0 first.
// - Address lines 0, 1, 2 double as low, high, upper latch strobes.
// - Address line 14 may carry chip select one instead.
// - High byte and low lane indicators mark the data phase lanes.
// - Strobe pins act as read/write or enable/direction per mode.
// - 16-bit data high bits use address lines or the upper data bus.
// - Mux select picks separate pins or one, two, three phases.
// - Port mode picks master, enhanced, buffered or legacy slave.
// - Each chip select finishes on its own acknowledge input.
// - Polarity bit makes latch strobes active high, else active low.
`timescale 1ns/1ps
module ppm_addr_data_mux
  import ppm_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire ppm_cfg_t          cfg,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_cs2,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              sw_out_wr,
  input  wire logic              sw_out_sel,
  input  wire logic [7:0]        sw_out_data,
  input  wire logic [14:0]       ext_addr_lines_i,
  input  wire logic [DATA_W-1:0] ext_data_lines_i,
  input  wire logic              write_strobe_i,
  input  wire logic              read_strobe_i,
  input  wire logic              slave_cs_i,
  input  wire logic              ack_in_one,
  input  wire logic              ack_in_two,
  output ppm_pins_t              pins_q,
  output logic                   busy_q,
  output logic                   done_q,
  output logic [DATA_W-1:0]      in_buf_a_q,
  output logic [DATA_W-1:0]      in_buf_b_q
);
  // ==========================================================
  // Helpers
  function automatic logic [4:0] span_bits(ppm_cfg_t c);
    if (c.port_width_sel == WID_4)
      return (c.addr_mux_sel == MUX_THREE) ? SPAN_16K : SPAN_1K;
    unique case (c.addr_mux_sel)
      MUX_TWO:   return SPAN_64K;
      MUX_THREE: return SPAN_2M;
      default:   return SPAN_1K;
    endcase
  endfunction

  // Address portion shown on the data lines in phase idx
  function automatic logic [7:0] phase_addr(ppm_cfg_t c,
                                            logic [ADDR_W-1:0] a,
                                            logic [1:0] idx);
    if (c.port_width_sel == WID_4) begin
      if (c.addr_mux_sel == MUX_ONE)
        return a[7:0];
      unique case (idx)
        2'h0:    return {4'h0, a[3:0]};
        2'h1:    return {4'h0, a[7:4]};
        default: return {4'h0, a[11:8]};
      endcase
    end
    unique case (idx)
      2'h0:    return a[7:0];
      2'h1:    return a[15:8];
      default: return {1'b0, a[22:16]};
    endcase
  endfunction

  // ==========================================================
  // Decode
  ppm_state_t        state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic              write_q;
  logic              cs2_q;
  logic [7:0]        out_a_q;
  logic [7:0]        out_b_q;
  logic              wr_prev_q;
  logic              rd_prev_q;
  logic              wptr_q;
  logic              rptr_q;
  logic [ADDR_W-1:0] span_mask;
  logic              is_master;
  logic              is_w4;
  logic              is_w16;
  logic              lat;
  logic              take;
  logic              ack_sel;
  logic              data_end;
  logic              host_wr;
  logic              host_rd;
  logic              host_rd_end;
  logic              wsel;
  logic              rsel;
  logic [DATA_W-1:0] rd_word;
  logic [7:0]        aoe;
  ppm_pins_t         pins_d;

  assign is_master = (cfg.port_mode == MODE_MASTER);
  assign is_w4     = (cfg.port_width_sel == WID_4);
  assign is_w16    = (cfg.port_width_sel == WID_16);
  assign lat       = cfg.latch_polarity_bit;
  assign take      = req_valid && is_master && state_q == ST_IDLE;
  assign ack_sel   = cs2_q ? ack_in_two : ack_in_one;
  assign data_end  = state_q == ST_DATA && ack_sel;
  assign host_wr   = !is_master && slave_cs_i && write_strobe_i && !wr_prev_q;
  assign host_rd   = !is_master && slave_cs_i && read_strobe_i;
  assign host_rd_end = !is_master && slave_cs_i && !read_strobe_i && rd_prev_q;
  assign aoe       = (is_w4 && cfg.addr_mux_sel != MUX_ONE) ? 8'h0F : 8'hFF;

  // Span clip: wider address bits never reach the pins
  always_comb begin
    span_mask = '0;
    for (int i = 0; i < ADDR_W; i++)
      span_mask[i] = (5'(i) < span_bits(cfg));
  end

  // Enhanced slave picks by address 0; buffered slave alternates
  always_comb begin
    unique case (cfg.port_mode)
      MODE_ENH: begin
        wsel = ext_addr_lines_i[0];
        rsel = ext_addr_lines_i[0];
      end
      MODE_BUF: begin
        wsel = wptr_q;
        rsel = rptr_q;
      end
      default: begin
        wsel = 1'b0;
        rsel = 1'b0;
      end
    endcase
  end

  // Read data gathered from whichever lines carry it
  always_comb begin
    if (is_w4)
      rd_word = {12'h000, ext_data_lines_i[3:0]};
    else if (!is_w16)
      rd_word = {8'h00, ext_data_lines_i[7:0]};
    else if (cfg.addr_mux_sel != MUX_DEMUX)
      rd_word = {1'b0, ext_addr_lines_i[14:8], ext_data_lines_i[7:0]};
    else
      rd_word = ext_data_lines_i;
  end

  // ==========================================================
  // Master sequencer: low, high, upper phases then data until ack
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:
          if (take)
            state_q <= (cfg.addr_mux_sel == MUX_DEMUX) ? ST_DATA
                                                       : ST_LOW;
        ST_LOW:
          state_q <= (cfg.addr_mux_sel[1]) ? ST_HIGH : ST_DATA;
        ST_HIGH:
          state_q <= (cfg.addr_mux_sel == MUX_THREE) ? ST_UPPER : ST_DATA;
        ST_UPPER:
          state_q <= ST_DATA;
        ST_DATA:
          if (ack_sel)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture; address clipped at entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q  <= '0;
      data_q  <= '0;
      write_q <= 1'b0;
      cs2_q   <= 1'b0;
    end else if (take) begin
      addr_q  <= req_addr & span_mask;
      data_q  <= req_data;
      write_q <= req_write;
      cs2_q   <= req_cs2;
    end
  end

  // ==========================================================
  // Buffers: slave in and out, master read holding
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_buf_a_q <= '0;
      in_buf_b_q <= '0;
    end else if (data_end && !write_q) begin
      in_buf_a_q <= rd_word;
    end else if (host_wr && !wsel) begin
      in_buf_a_q <= {8'h00, ext_data_lines_i[7:0]};
    end else if (host_wr) begin
      in_buf_b_q <= {8'h00, ext_data_lines_i[7:0]};
    end
  end

  // Software fills the outgoing pair
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_a_q <= 8'h00;
      out_b_q <= 8'h00;
    end else if (sw_out_wr && !sw_out_sel) begin
      out_a_q <= sw_out_data;
    end else if (sw_out_wr) begin
      out_b_q <= sw_out_data;
    end
  end

  // Strobe history and buffered-slave pointers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      wptr_q    <= 1'b0;
      rptr_q    <= 1'b0;
    end else begin
      wr_prev_q <= write_strobe_i;
      rd_prev_q <= read_strobe_i;
      if (host_wr && cfg.port_mode == MODE_BUF)
        wptr_q <= !wptr_q;
      if (host_rd_end && cfg.port_mode == MODE_BUF)
        rptr_q <= !rptr_q;
    end
  end

  // ==========================================================
  // Pin image, registered below so every pin leaves a flop
  always_comb begin
    pins_d = '0;
    if (is_master) begin
      pins_d.ext_addr_lines = addr_q;
      pins_d.ext_addr_oe    = '1;
      // Idle latch strobes sit at their inactive level
      if (cfg.addr_mux_sel != MUX_DEMUX)
        pins_d.ext_addr_lines[0] = !lat;
      if (cfg.addr_mux_sel[1])
        pins_d.ext_addr_lines[1] = !lat;
      if (cfg.addr_mux_sel == MUX_THREE)
        pins_d.ext_addr_lines[2] = !lat;
      pins_d.chip_sel_one    = state_q != ST_IDLE && !cs2_q;
      pins_d.chip_sel_two    = state_q != ST_IDLE && cs2_q;
      pins_d.write_strobe_oe = 1'b1;
      pins_d.read_strobe_oe  = 1'b1;
      unique case (state_q)
        ST_LOW: begin
          pins_d.ext_addr_lines[0]   = lat;
          pins_d.ext_data_lines[7:0] = phase_addr(cfg, addr_q, 2'h0);
          pins_d.ext_data_oe[7:0]    = aoe;
        end
        ST_HIGH: begin
          pins_d.ext_addr_lines[1]   = lat;
          pins_d.ext_data_lines[7:0] = phase_addr(cfg, addr_q, 2'h1);
          pins_d.ext_data_oe[7:0]    = aoe;
        end
        ST_UPPER: begin
          pins_d.ext_addr_lines[2]   = lat;
          pins_d.ext_data_lines[7:0] = phase_addr(cfg, addr_q, 2'h2);
          pins_d.ext_data_oe[7:0]    = aoe;
        end
        ST_DATA: begin
          pins_d.low_lane_indicator  = 1'b1;
          pins_d.high_byte_indicator = is_w16;
          // Enable/direction pair, or separate write and read strobes
          pins_d.write_strobe_pin = cfg.strobe_mode_bit[cs2_q] || write_q;
          pins_d.read_strobe_pin  = !write_q;
          if (write_q) begin
            pins_d.ext_data_lines = data_q;
            pins_d.ext_data_oe    = is_w4 ? 16'h000F :
                                    (is_w16 && cfg.addr_mux_sel ==
                                     MUX_DEMUX) ? 16'hFFFF : 16'h00FF;
          end
          if (is_w16 && cfg.addr_mux_sel != MUX_DEMUX) begin
            pins_d.ext_addr_lines[14:8] = data_q[14:8];
            pins_d.ext_addr_oe[14:8]    = {7{write_q}};
          end
        end
        default: ;
      endcase
      // Chip select one overrides bit 14, data included
      if (cfg.cs1_on_addr14) begin
        pins_d.ext_addr_lines[14] = pins_d.chip_sel_one;
        pins_d.ext_addr_oe[14]    = 1'b1;
      end
    end else begin
      pins_d.ext_data_lines[7:0] = rsel ? out_b_q : out_a_q;
      pins_d.ext_data_oe[7:0]    = {8{host_rd}};
    end
  end

  // Output flops; pins lag the sequencer state by one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      busy_q <= take || (state_q != ST_IDLE && !data_end);
      done_q <= data_end;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_slave_drive;
    host_rd |=> pins_q.ext_data_oe[7:0] == 8'hFF;
  endproperty
  a_slave_drive: assert property (p_slave_drive)
    else $error("slave read not driven");
  property p_slave_capture;
    host_wr && cfg.port_mode == MODE_LEGACY
      |=> in_buf_a_q[7:0] == $past(ext_data_lines_i[7:0]);
  endproperty
  a_slave_capture: assert property (p_slave_capture)
    else $error("slave write lost");
  property p_read_hold;
    data_end && !write_q |=> in_buf_a_q == $past(rd_word);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("master read not held");
  property p_three_phase;
    take && cfg.addr_mux_sel == MUX_THREE
      |=> state_q == ST_LOW ##1 state_q == ST_HIGH
          ##1 state_q == ST_UPPER ##1 state_q == ST_DATA;
  endproperty
  a_three_phase: assert property (p_three_phase)
    else $error("phase order wrong");
  property p_low_strobe;
    state_q == ST_LOW |=> pins_q.ext_addr_lines[0] == $past(lat);
  endproperty
  a_low_strobe: assert property (p_low_strobe)
    else $error("low strobe level wrong");
  property p_strobe_idle;
    state_q == ST_DATA && cfg.addr_mux_sel != MUX_DEMUX
      |=> pins_q.ext_addr_lines[0] != $past(lat);
  endproperty
  a_strobe_idle: assert property (p_strobe_idle)
    else $error("strobe active in data phase");
  property p_cs_on_a14;
    is_master && cfg.cs1_on_addr14
      |=> pins_q.ext_addr_lines[14] == pins_q.chip_sel_one;
  endproperty
  a_cs_on_a14: assert property (p_cs_on_a14)
    else $error("line 14 not chip select");
  property p_ack_end;
    data_end |=> state_q == ST_IDLE && done_q ##1 !done_q;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge did not end access");
  property p_lane;
    state_q == ST_DATA |=> pins_q.low_lane_indicator;
  endproperty
  a_lane: assert property (p_lane)
    else $error("low lane indicator missing");
  property p_nibble_addr;
    state_q == ST_LOW && is_w4 && cfg.addr_mux_sel == MUX_ONE
      |=> pins_q.ext_data_lines[7:0] == $past(addr_q[7:0]);
  endproperty
  a_nibble_addr: assert property (p_nibble_addr)
    else $error("one-phase nibble address wrong");

  c_three: cover property (take && cfg.addr_mux_sel == MUX_THREE);
  c_slave_wr: cover property (host_wr && cfg.port_mode == MODE_BUF);
  c_read: cover property (data_end && !write_q);
endmodule // ppm_addr_data_mux

// ==== bench/ppm_ext_dev.sv ====
// Model of the external memory or peripheral facing the port pins
`timescale 1ns/1ps
module ppm_ext_dev
  import ppm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  ppm_pins_t        pins,
  input  wire logic        pol,
  input  wire logic [1:0]  mux,
  input  wire logic        cs14,
  input  wire logic [1:0]  dly,
  input  wire logic [15:0] rd_val,
  output logic             ack_one,
  output logic             ack_two,
  output logic [15:0]      drv,
  output ppm_pins_t        snap,
  output logic [7:0]       lat_lo,
  output logic [7:0]       lat_hi,
  output logic [7:0]       lat_up,
  output logic [1:0]       ph,
  output logic             err
);
  logic [2:0]  stb;
  logic [2:0]  en;
  logic [2:0]  stb_q;
  logic        cs;
  logic        dp;
  logic [1:0]  cnt;
  logic [15:0] last_q;
  // ==========================================================
  // Pin decode
  assign cs  = pins.chip_sel_one | pins.chip_sel_two
             | (cs14 & pins.ext_addr_lines[14]);
  // Only lines that the phase count turns into strobes are decoded;
  // the others carry plain address bits and must not look like strobes
  assign en  = {mux == 2'h3, mux[1], mux != 2'h0};
  assign stb = cs ? (~(pins.ext_addr_lines[2:0] ^ {3{pol}}) & en)
                  : 3'h0;
  assign dp  = cs & pins.low_lane_indicator & (stb == 3'h0);
  // Acknowledge after a set delay, one input per chip select
  assign ack_one = dp & ~pins.chip_sel_two & (cnt >= dly);
  assign ack_two = dp & pins.chip_sel_two & (cnt >= dly);
  // Released bus shows the inverse of its last value, not a held copy
  assign drv = (dp & pins.read_strobe_pin) ? rd_val : ~last_q;
  // ==========================================================
  // Address latches, phase order and data phase snapshot
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_q <= 16'h0000;
      stb_q  <= 3'h0;
      cnt    <= 2'h0;
      ph     <= 2'h0;
      err    <= 1'b0;
      snap   <= '0;
      lat_lo <= 8'h00;
      lat_hi <= 8'h00;
      lat_up <= 8'h00;
    end else begin
      last_q <= drv;
      stb_q  <= stb;
      cnt    <= dp ? cnt + 2'(cnt != 2'h3) : 2'h0;
      if (!cs) ph <= 2'h0;
      if (dp) snap <= pins;
      if (stb != 3'h0 && stb != stb_q) begin
        err <= err | (stb != (3'h1 << ph));
        ph  <= ph + 2'h1;
      end
      if (stb[0]) lat_lo <= pins.ext_data_lines[7:0];
      if (stb[1]) lat_hi <= pins.ext_data_lines[7:0];
      if (stb[2]) lat_up <= pins.ext_data_lines[7:0];
    end
  end
endmodule // ppm_ext_dev

// ==== bench/tb.sv ====
// Self-checking testbench of the parallel port address/data mux
`timescale 1ns/1ps
module tb
  import ppm_pkg::*;
;
  logic              ref_clk, nrst, req_valid, req_write, req_cs2;
  ppm_cfg_t          cfg;
  logic [ADDR_W-1:0] req_addr, a;
  logic [DATA_W-1:0] req_data, d, e, rd_val, drv, in_buf_a_q, in_buf_b_q;
  logic              sw_out_wr, sw_out_sel, wr_i, rd_i, scs_i, host_on;
  logic [7:0]        sw_out_data, h_data, lat_lo, lat_hi, lat_up;
  logic              h_a0, busy_q, done_q, ack_one, ack_two, err;
  logic [1:0]        dly, ph, w, m;
  ppm_pins_t         pins_q, snap;
  int                n_fail, samples_checked, cyc;

  ppm_addr_data_mux dut (.ref_clk, .nrst, .cfg, .req_valid, .req_write,
    .req_cs2, .req_addr, .req_data, .sw_out_wr, .sw_out_sel, .sw_out_data,
    .ext_addr_lines_i({drv[14:1], host_on ? h_a0 : drv[0]}),
    .ext_data_lines_i(host_on ? {drv[15:8], h_data} : drv),
    .write_strobe_i(wr_i), .read_strobe_i(rd_i), .slave_cs_i(scs_i),
    .ack_in_one(ack_one), .ack_in_two(ack_two), .pins_q, .busy_q, .done_q,
    .in_buf_a_q, .in_buf_b_q);

  ppm_ext_dev dev (.ref_clk, .nrst, .pins(pins_q),
    .pol(cfg.latch_polarity_bit), .mux(cfg.addr_mux_sel),
    .cs14(cfg.cs1_on_addr14), .dly, .rd_val, .ack_one, .ack_two, .drv,
    .snap, .lat_lo, .lat_hi, .lat_up, .ph, .err);

  // ==========================================================
  // Clock and hang guard, about 190 cycles expected
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  // Master access; returns in the done cycle so calls run back to back
  task automatic mreq(input logic wr);
    int n;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_data  = d;
    tick();
    req_valid = 1'b0;
    chk("busy", busy_q, 1);
    chk("done_pulse", done_q, 0);
    n = 0;
    while (done_q !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("done", done_q, 1);
  endtask
  task automatic swr(input logic sel, input logic [7:0] v);
    sw_out_sel  = sel;
    sw_out_data = v;
    sw_out_wr   = 1'b1;
    tick();
    sw_out_wr   = 1'b0;
    tick();
  endtask
  // Host write: strobe rises with select held, data steady throughout
  task automatic hwr(input logic a0, input logic [7:0] v);
    h_a0   = a0;
    h_data = v;
    scs_i  = 1'b1;
    tick();
    wr_i   = 1'b1;
    repeat (2) tick();
    wr_i   = 1'b0;
    scs_i  = 1'b0;
    tick();
  endtask
  task automatic hrd(input logic a0, input logic [7:0] v);
    h_a0  = a0;
    scs_i = 1'b1;
    rd_i  = 1'b1;
    repeat (2) tick();
    chk("slave_out", pins_q.ext_data_lines[7:0], v);
    chk("slave_oe", pins_q.ext_data_oe[7:0], 8'hFF);
    // Strobe falls while still selected, so the buffered pointer steps
    rd_i  = 1'b0;
    tick();
    scs_i = 1'b0;
    tick();
    chk("slave_oe_off", pins_q.ext_data_oe[7:0], 0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {nrst, req_valid, req_write, req_cs2, req_addr, req_data} = '0;
    {sw_out_wr, sw_out_sel, sw_out_data, wr_i, rd_i, scs_i} = '0;
    {host_on, h_data, h_a0, dly, rd_val, a, d} = '0;
    {n_fail, samples_checked, cyc} = '0;
    cfg = '0;
    cfg.port_mode = MODE_MASTER;
    repeat (4) @(posedge ref_clk);
    chk("reset_pins", {31'h0, |pins_q}, 0);
    #1 nrst = 1'b1;
    // Every width and mux code, both directions, both polarities
    for (int i = 0; i < 12; i++) begin
      // Let the pins go idle before the partner sees new settings
      tick();
      w = (i < 4) ? WID_8 : (i < 8) ? WID_4 : WID_16;
      m = 2'(i);
      cfg.port_width_sel = w;
      cfg.addr_mux_sel = m;
      cfg.latch_polarity_bit = i[0];
      cfg.strobe_mode_bit = {2{i[1]}};
      req_cs2 = i[2];
      a = 23'h5AC396 ^ 23'(i << 3);
      d = 16'hA5C3 ^ 16'(i);
      dly = 2'(i % 3);
      rd_val = ~d;
      for (int k = 1; k >= 0; k--) begin
        mreq(k[0]);
        chk("phases", ph, m);
        chk("order", err, 0);
        chk("rd_strobe", snap.read_strobe_pin, !k[0]);
        chk("wr_strobe", snap.write_strobe_pin, k[0] | i[1]);
        chk("cs", {snap.chip_sel_two, snap.chip_sel_one},
          i[2] ? 2 : 1);
        chk("hi_byte", snap.high_byte_indicator, w == WID_16);
        if (m == 0) chk("addr", snap.ext_addr_lines, a[9:0]);
        if (m != 0) chk("lat_lo", (w == WID_4 && m > 1) ? lat_lo[3:0] : lat_lo,
          (w == WID_4 && m > 1) ? a[3:0] : a[7:0]);
        if (m > 1) chk("lat_hi", w == WID_4 ? lat_hi[3:0] : lat_hi,
          w == WID_4 ? a[7:4] : a[15:8]);
        if (m == 3) chk("lat_up", w == WID_4 ? lat_up[3:0] : lat_up,
          w == WID_4 ? a[11:8] : {2'h0, a[20:16]});
        if (m != 0 && w == WID_4) chk("addr_hi", m == 3 ?
          snap.ext_addr_lines[13:12] : snap.ext_addr_lines[9:8],
          m == 3 ? a[13:12] : a[9:8]);
        if (k == 1) begin
          chk("wdata", w == WID_4 ? snap.ext_data_lines[3:0] :
            snap.ext_data_lines[7:0], w == WID_4 ? d[3:0] : d[7:0]);
          chk("wdata_oe", snap.ext_data_oe, w == WID_4 ? 16'h000F :
            (w == WID_16 && m == 0) ? 16'hFFFF : 16'h00FF);
          if (w == WID_16) chk("wdata_hi", m == 0 ?
            snap.ext_data_lines[15:8] : {1'b0, snap.ext_addr_lines[14:8]},
            m == 0 ? d[15:8] : {1'b0, d[14:8]});
        end else begin
          e = w == WID_4 ? {12'h000, rd_val[3:0]} : w == WID_8 ?
            {8'h00, rd_val[7:0]} : m == 0 ? rd_val : {1'b0, rd_val[14:0]};
          chk("rd_capture", in_buf_a_q, e);
          chk("rd_oe", snap.ext_data_oe, 0);
        end
      end
    end
    // Chip select one moved onto address line 14
    cfg = '0;
    cfg.port_mode = MODE_MASTER;
    cfg.cs1_on_addr14 = 1'b1;
    {req_cs2, a} = '0;
    mreq(1'b1);
    chk("cs_on_line14", snap.ext_addr_lines[14], 1);
    // Requests are ignored in slave modes
    cfg = '0;
    req_valid = 1'b1;
    repeat (3) tick();
    req_valid = 1'b0;
    chk("refused", {busy_q, pins_q.chip_sel_one, pins_q.chip_sel_two}, 0);
    // Slave modes: legacy, enhanced by address, buffered alternating
    host_on = 1'b1;
    swr(1'b0, 8'h3C);
    swr(1'b1, 8'hC3);
    hrd(1'b0, 8'h3C);
    hwr(1'b0, 8'h81);
    chk("legacy_in", in_buf_a_q, 16'h0081);
    cfg.port_mode = MODE_ENH;
    hwr(1'b1, 8'h42);
    chk("enh_in", in_buf_b_q, 16'h0042);
    hrd(1'b1, 8'hC3);
    cfg.port_mode = MODE_BUF;
    hwr(1'b0, 8'h11);
    hwr(1'b0, 8'h22);
    chk("buf_in_a", in_buf_a_q, 16'h0011);
    chk("buf_in_b", in_buf_b_q, 16'h0022);
    hrd(1'b0, 8'h3C);
    hrd(1'b0, 8'hC3);
    results();
  end
endmodule // tb
